/* File: trigger_sequencer.sv */
// Peripheral trigger sequencer: step queue, timers, loop counters, watchdog.
// Assumes a classic Wishbone master on clk_i; trigger and clock-source
// inputs come from other domains and are synchronised here.
`timescale 1ns/1ps
import seq_pkg::*;

// Function
// RL1: Run 8-bit step commands from eight queue registers as the program.
// RL2: Steps wait for inputs, emit triggers, and wait for timers.
// RL3: Two 16-bit timers and two 16-bit loop counters.
// RL4: Accept trigger inputs from converter, modulator, capture, compare, comparator, interrupt.
// RL5: Drive trigger or sync outputs to peripherals including the watchdog.
// RL6: Input detection responds to rising or falling edges.
// RL7: Four configurable interrupts, per-step interrupt in single-step, watchdog interrupt.
// RL8: Own step watchdog, independent of the device watchdog.
// RL9: Control bit 15 enables the module.
// RL10: Control bit 13 stops the module while the device idles.
// RL11: Bit 12 makes trigger steps toggle outputs instead of pulsing.
// RL12: Writing one to bit 10 gives a software trigger; zero does nothing.
// RL13: Bit 9 selects single-step mode.
// RL14: Bit 8 makes limit registers read back live counter values.
// RL15: Bit 7 starts continuous step execution; clearing it stops.
// RL16: Bit 6 is set by hardware on watchdog time-out.
// RL17: Wait mode picks edge or level detection, with or without exit delay.
// RL18: Clock source select picks one of six clocks; two codes reserved.
// RL19: Prescaler divides the selected clock by value plus one.
// RL20: Trigger pulses last pulse-width value plus one module clocks.
// RL21: Watchdog limit disables or selects 8 to 512 module clocks.
// RL22: Disabling halts steps and clears pointer, timers and counters.
// RL23: Watchdog counts only during waits and restarts on each step.
module trigger_sequencer (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  input  wire logic                         we_i,
  input  wire logic [seq_pkg::ADR_W-1:0]    adr_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic [31:0]                  dat_i,
  output logic      [31:0]                  dat_o,
  output logic                              ack_o,
  input  wire logic                         idle_i,
  input  wire logic [seq_pkg::NUM_IN-1:0]   trig_in_i,
  input  wire logic [seq_pkg::NUM_SRC-1:0]  clk_src_i,
  output logic      [seq_pkg::NUM_OUT-1:0]  trig_out_o,
  output logic      [seq_pkg::NUM_IRQ-1:0]  irq_o,
  output logic                              step_irq_o,
  output logic                              wdt_irq_o
);
  import seq_pkg::*;

  typedef struct packed {
    logic       en, sidl, togl, swt, ssen, ivis, run, wdto;
    logic [1:0] itm;
    logic [15:0] cfg, t0lim, t1lim, sdlim, c0lim, c1lim;
    logic [15:0] t0, t1, sd, c0, c1, pulse, tog, trig, prev_in;
    logic [4:0] prev_src, div_cnt;
    logic [9:0] wdt_cnt;
    logic [3:0] pw_cnt, irq;
    logic [2:0] ptr;
    seq_state_t state;
    logic       ack, qsel, step_irq, wdt_irq;
    logic [31:0] dat;
  } st_t;

  st_t s_reg;
  st_t s_next;

  logic [NUM_IN-1:0]  in_s;
  logic [NUM_SRC-1:0] src_s;
  logic [7:0]         qrd;
  logic [7:0]         qbus;
  logic [7:0]         aw;
  logic               qwr;

  // ****************************************************************
  // Input synchronisers and step queue
  // ****************************************************************
  seq_sync2 #(.W(NUM_IN)) u_sync_in (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (trig_in_i),   // RL4
    .q_o   (in_s)
  );

  seq_sync2 #(.W(NUM_SRC)) u_sync_src (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (clk_src_i),
    .q_o   (src_s)
  );

  assign aw  = {adr_i[ADR_W-1:2], 2'h0};
  assign qwr = cyc_i & stb_i & we_i & ~s_reg.ack & sel_i[0] & (aw[7:5] == OFS_QUE[7:5]);

  seq_queue_mem u_queue (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .wr_en_i     (qwr),            // RL1
    .wr_addr_i   (adr_i[4:2]),
    .wr_data_i   (dat_i[7:0]),
    .rd_addr_a_i (s_reg.ptr),
    .rd_data_a_o (qrd),
    .rd_addr_b_i (adr_i[4:2]),
    .rd_data_b_o (qbus)
  );

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
    wmerge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic        act, src_ev, tick, fin, jmp, done, wdto_set, req;
  logic [3:0]  op, opt;
  logic [4:0]  src_rise;
  logic [2:0]  csel;
  logic [9:0]  wlim;
  logic [15:0] cst, w;
  logic        inb, inp;

  always_comb begin
    s_next   = s_reg;
    act      = 1'b0;
    src_ev   = 1'b0;
    tick     = 1'b0;
    fin      = 1'b0;
    jmp      = 1'b0;
    done     = 1'b0;
    wdto_set = 1'b0;
    op       = qrd[7:4];
    opt      = qrd[3:0];
    inb      = in_s[opt];
    inp      = s_reg.prev_in[opt];
    src_rise = src_s & ~s_reg.prev_src;
    csel     = s_reg.cfg[CON_CLK +: 3];
    wlim     = WDOG_BASE << (s_reg.cfg[CON_WDT +: 3] - 3'h1);   // RL21
    cst      = {s_reg.en, 1'h0, s_reg.sidl, s_reg.togl, 1'h0, s_reg.swt, s_reg.ssen,
                s_reg.ivis, s_reg.run, s_reg.wdto, 4'h0, s_reg.itm};
    w        = 16'h0000;
    req      = cyc_i & stb_i & ~s_reg.ack;
    s_next.irq      = 4'h0;
    s_next.step_irq = 1'b0;
    s_next.wdt_irq  = 1'b0;
    s_next.prev_in  = in_s;
    s_next.prev_src = src_s;

    // Module clock: source select then prescaler, both as enables
    act = s_reg.en & ~(s_reg.sidl & idle_i);   // RL9 RL10
    if (csel == 3'h0) begin
      src_ev = 1'b1;   // RL18
    end else if (csel <= 3'h5) begin
      src_ev = src_rise[3'(csel - 3'h1)];   // RL18
    end
    if (act && src_ev) begin
      if (s_reg.div_cnt == s_reg.cfg[CON_DIV +: 5]) begin
        tick           = 1'b1;   // RL19
        s_next.div_cnt = 5'h00;
      end else begin
        s_next.div_cnt = s_reg.div_cnt + 5'h01;
      end
    end

    // Pulse width counts module clocks, shared by all pulsing outputs
    if (tick && s_reg.pulse != 16'h0000) begin
      if (s_reg.pw_cnt == s_reg.cfg[CON_PWD +: 4]) begin
        s_next.pulse = 16'h0000;   // RL20
      end else begin
        s_next.pw_cnt = s_reg.pw_cnt + 4'h1;
      end
    end

    // Step engine; frozen entirely while stopped in idle
    if (act) begin
      if (!s_reg.run) begin
        s_next.state = S_IDLE;   // RL15
      end else begin
        unique case (s_reg.state)
          S_IDLE: begin
            s_next.state = S_FETCH;   // RL15
          end
          S_FETCH: begin
            s_next.state = S_EXEC;
          end
          S_EXEC: begin
            unique case (op)
              OP_CTRL: begin
                if (opt == OPT_NOP) begin
                  fin = 1'b1;
                end else begin
                  s_next.state = S_WAIT;   // RL2
                  if (opt == OPT_T0) s_next.t0 = 16'h0000;
                  if (opt == OPT_T1) s_next.t1 = 16'h0000;
                  if (opt == OPT_SD) s_next.sd = 16'h0000;
                end
              end
              OP_WHI, OP_WLO: begin
                s_next.state = S_WAIT;   // RL2
              end
              OP_TRIG: begin
                if (s_reg.togl) begin
                  s_next.tog[opt] = ~s_reg.tog[opt];   // RL11
                end else begin
                  s_next.pulse[opt] = 1'b1;   // RL11
                  s_next.pw_cnt     = 4'h0;
                end
                fin = 1'b1;
              end
              OP_IRQ: begin
                s_next.irq[opt[1:0]] = 1'b1;   // RL7
                fin = 1'b1;
              end
              OP_LOOP0: begin
                fin = 1'b1;
                if (s_reg.c0 == s_reg.c0lim) begin
                  s_next.c0 = 16'h0000;   // RL3
                end else begin
                  s_next.c0 = s_reg.c0 + 16'h0001;
                  jmp = 1'b1;
                end
              end
              OP_LOOP1: begin
                fin = 1'b1;
                if (s_reg.c1 == s_reg.c1lim) begin
                  s_next.c1 = 16'h0000;   // RL3
                end else begin
                  s_next.c1 = s_reg.c1 + 16'h0001;
                  jmp = 1'b1;
                end
              end
              OP_JUMP: begin
                fin = 1'b1;
                jmp = 1'b1;
              end
              default: begin
                fin = 1'b1;   // Unassigned opcodes act as no-ops
              end
            endcase
          end
          S_WAIT: begin
            // Edge modes look at the last two samples, level modes at one
            if (op == OP_WHI) begin
              done = s_reg.itm[1] ? inb : (inb & ~inp);   // RL6 RL17
            end else if (op == OP_WLO) begin
              done = s_reg.itm[1] ? ~inb : (~inb & inp);   // RL6 RL17
            end else if (opt == OPT_T0) begin
              done = (s_reg.t0 == s_reg.t0lim);   // RL3
            end else if (opt == OPT_T1) begin
              done = (s_reg.t1 == s_reg.t1lim);   // RL3
            end else if (opt == OPT_SWT) begin
              done = s_reg.swt;   // RL12
              s_next.swt = 1'b0;
            end else begin
              done = (s_reg.sd == s_reg.sdlim);
            end
            if (done) begin
              if (op != OP_CTRL && !s_reg.itm[0]) begin
                s_next.sd    = 16'h0000;   // RL17
                s_next.state = S_DELAY;
              end else begin
                fin = 1'b1;
              end
            end else if (tick) begin
              if (op == OP_CTRL && opt == OPT_T0) s_next.t0 = s_reg.t0 + 16'h0001;
              if (op == OP_CTRL && opt == OPT_T1) s_next.t1 = s_reg.t1 + 16'h0001;
              if (op == OP_CTRL && opt == OPT_SD) s_next.sd = s_reg.sd + 16'h0001;
              s_next.wdt_cnt = s_reg.wdt_cnt + 10'h001;   // RL23
              if (s_reg.cfg[CON_WDT +: 3] != 3'h0 && s_reg.wdt_cnt == wlim - 10'h001) begin
                wdto_set = 1'b1;   // RL8 RL21
              end
            end
          end
          S_DELAY: begin
            if (s_reg.sd == s_reg.sdlim) begin
              fin = 1'b1;
            end else if (tick) begin
              s_next.sd = s_reg.sd + 16'h0001;
            end
          end
          S_HOLD: begin
            if (s_reg.swt) begin
              s_next.swt   = 1'b0;   // RL13
              s_next.state = S_FETCH;
            end
          end
        endcase
      end
    end

    // Step completion: advance, wrap after the last entry, restart watchdog
    if (fin) begin
      s_next.ptr      = jmp ? opt[2:0] : s_reg.ptr + 3'h1;   // RL1
      s_next.wdt_cnt  = 10'h000;   // RL23
      s_next.step_irq = s_reg.ssen;   // RL7 RL13
      s_next.state    = s_reg.ssen ? S_HOLD : S_FETCH;   // RL13
    end

    // ****************************************************************
    // Wishbone slave: one-cycle ack, unmapped reads zero
    // ****************************************************************
    s_next.ack  = req;
    s_next.qsel = req & ~we_i & (aw[7:5] == OFS_QUE[7:5]);
    if (req && !we_i) begin
      unique case (aw)
        OFS_CST:   s_next.dat = {16'h0000, cst};
        OFS_CON:   s_next.dat = {16'h0000, s_reg.cfg};
        OFS_T0LIM: s_next.dat = {16'h0000, s_reg.ivis ? s_reg.t0 : s_reg.t0lim};   // RL14
        OFS_T1LIM: s_next.dat = {16'h0000, s_reg.ivis ? s_reg.t1 : s_reg.t1lim};   // RL14
        OFS_SDLIM: s_next.dat = {16'h0000, s_reg.ivis ? s_reg.sd : s_reg.sdlim};   // RL14
        OFS_C0LIM: s_next.dat = {16'h0000, s_reg.ivis ? s_reg.c0 : s_reg.c0lim};   // RL14
        OFS_C1LIM: s_next.dat = {16'h0000, s_reg.ivis ? s_reg.c1 : s_reg.c1lim};   // RL14
        default:   s_next.dat = 32'h0000_0000;
      endcase
    end
    if (req && we_i) begin
      unique case (aw)
        OFS_CST: begin
          w = wmerge(cst, dat_i, sel_i);
          s_next.en   = w[CST_EN];   // RL9
          s_next.sidl = w[CST_SIDL];
          s_next.togl = w[CST_TOGL];
          s_next.ssen = w[CST_SSEN];
          s_next.ivis = w[CST_IVIS];
          s_next.run  = w[CST_RUN];   // RL15
          s_next.itm  = w[CST_ITM +: 2];
          if (sel_i[1] && dat_i[CST_SWT]) s_next.swt = 1'b1;   // RL12
          if (sel_i[0] && !dat_i[CST_WDTO]) s_next.wdto = 1'b0;
        end
        OFS_CON:   s_next.cfg   = wmerge(s_reg.cfg, dat_i, sel_i) & CON_MASK;
        OFS_T0LIM: s_next.t0lim = wmerge(s_reg.t0lim, dat_i, sel_i);
        OFS_T1LIM: s_next.t1lim = wmerge(s_reg.t1lim, dat_i, sel_i);
        OFS_SDLIM: s_next.sdlim = wmerge(s_reg.sdlim, dat_i, sel_i);
        OFS_C0LIM: s_next.c0lim = wmerge(s_reg.c0lim, dat_i, sel_i);
        OFS_C1LIM: s_next.c1lim = wmerge(s_reg.c1lim, dat_i, sel_i);
        default: begin
        end
      endcase
    end

    // Time-out wins over a same-cycle software clear and halts the run
    if (wdto_set) begin
      s_next.wdto    = 1'b1;   // RL16
      s_next.wdt_irq = 1'b1;   // RL7
      s_next.run     = 1'b0;
      s_next.state   = S_IDLE;
      s_next.wdt_cnt = 10'h000;
    end

    // Disabled module returns to its initial sequencing state
    if (!s_next.en) begin
      s_next.state   = S_IDLE;   // RL22
      s_next.ptr     = 3'h0;
      s_next.t0      = 16'h0000;
      s_next.t1      = 16'h0000;
      s_next.sd      = 16'h0000;
      s_next.c0      = 16'h0000;
      s_next.c1      = 16'h0000;
      s_next.pulse   = 16'h0000;
      s_next.tog     = 16'h0000;
      s_next.wdt_cnt = 10'h000;
      s_next.div_cnt = 5'h00;
    end
    s_next.trig = s_next.tog | s_next.pulse;   // RL5
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register; queue reads take dat_o from the queue port b register
  assign dat_o      = s_reg.qsel ? {24'h000000, qbus} : s_reg.dat;
  assign ack_o      = s_reg.ack;
  assign trig_out_o = s_reg.trig;
  assign irq_o      = s_reg.irq;
  assign step_irq_o = s_reg.step_irq;
  assign wdt_irq_o  = s_reg.wdt_irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  a_ack_drops: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");
  a_disable_clr: assert property (!s_reg.en |-> s_reg.state == S_IDLE && s_reg.ptr == 3'h0 && s_reg.tog == 16'h0000) // RL22
    else $error("disabled module not cleared");
  a_run_stop: assert property (s_reg.en && !idle_i && !s_reg.run |=> s_reg.state == S_IDLE) // RL15
    else $error("steps continue after run cleared");
  a_idle_freeze: assert property (s_reg.en && s_reg.sidl && idle_i && !(cyc_i && stb_i && we_i) |=> $stable(s_reg.ptr)) // RL10
    else $error("pointer moved while stopped in idle");
  a_wdt_flag: assert property (wdt_irq_o |-> s_reg.wdto && s_reg.state == S_IDLE && !s_reg.run) // RL16
    else $error("time-out did not set flag and halt");
  a_wdt_only_wait: assert property (s_reg.state != S_WAIT |=> !wdt_irq_o) // RL23
    else $error("watchdog fired outside a wait");
  a_step_hold: assert property (step_irq_o |-> s_reg.ssen && s_reg.state == S_HOLD) // RL13
    else $error("step event without hold");
  a_toggle_flip: assert property (s_reg.en && s_reg.run && !idle_i && s_reg.state == S_EXEC && op == OP_TRIG && s_reg.togl |=> s_reg.tog != $past(s_reg.tog)) // RL11
    else $error("toggle step left outputs unchanged");
  a_pulse_one: assert property (s_reg.cfg == 16'h0000 && $rose(s_reg.pulse[1]) && s_reg.en && !idle_i |=> !s_reg.pulse[1]) // RL20
    else $error("minimum pulse longer than one clock");

  c_trig_pulse: cover property ($rose(trig_out_o[0]));
  c_wdt_timeout: cover property (wdt_irq_o);
  c_step_event: cover property (step_irq_o);
  c_loop_jump: cover property (s_reg.state == S_EXEC && op == OP_LOOP0 && s_reg.c0 != s_reg.c0lim);
endmodule

/* File: seq_pkg.sv */
// Constants shared by the trigger sequencer, its testbench and its bus map.
// Assumes a 32-bit classic Wishbone slave with byte addresses on adr_i.
package seq_pkg;

  // ****************************************************************
  // Bus map
  // ****************************************************************
  localparam int unsigned ADR_W     = 8;
  localparam logic [7:0]  OFS_CST   = 8'h00;
  localparam logic [7:0]  OFS_CON   = 8'h04;
  localparam logic [7:0]  OFS_T0LIM = 8'h08;
  localparam logic [7:0]  OFS_T1LIM = 8'h0C;
  localparam logic [7:0]  OFS_SDLIM = 8'h10;
  localparam logic [7:0]  OFS_C0LIM = 8'h14;
  localparam logic [7:0]  OFS_C1LIM = 8'h18;
  localparam logic [7:0]  OFS_QUE   = 8'h20;

  // ****************************************************************
  // Control/status and configuration fields
  // ****************************************************************
  localparam int unsigned CST_EN   = 15;
  localparam int unsigned CST_SIDL = 13;
  localparam int unsigned CST_TOGL = 12;
  localparam int unsigned CST_SWT  = 10;
  localparam int unsigned CST_SSEN = 9;
  localparam int unsigned CST_IVIS = 8;
  localparam int unsigned CST_RUN  = 7;
  localparam int unsigned CST_WDTO = 6;
  localparam int unsigned CST_ITM  = 0;
  localparam int unsigned CON_CLK  = 13;
  localparam int unsigned CON_DIV  = 8;
  localparam int unsigned CON_PWD  = 4;
  localparam int unsigned CON_WDT  = 0;
  localparam logic [15:0] CON_MASK = 16'hFFF7;
  localparam logic [15:0] REG_RST  = 16'h0000;

  // ****************************************************************
  // Step commands: opcode in [7:4], option in [3:0]
  // ****************************************************************
  localparam logic [3:0] OP_CTRL  = 4'h0;
  localparam logic [3:0] OP_WHI   = 4'h1;
  localparam logic [3:0] OP_WLO   = 4'h2;
  localparam logic [3:0] OP_TRIG  = 4'h3;
  localparam logic [3:0] OP_IRQ   = 4'h4;
  localparam logic [3:0] OP_LOOP0 = 4'h5;
  localparam logic [3:0] OP_LOOP1 = 4'h6;
  localparam logic [3:0] OP_JUMP  = 4'h7;
  localparam logic [3:0] OPT_NOP  = 4'h0;
  localparam logic [3:0] OPT_T0   = 4'h1;
  localparam logic [3:0] OPT_T1   = 4'h2;
  localparam logic [3:0] OPT_SWT  = 4'h3;
  localparam logic [3:0] OPT_SD   = 4'h4;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int unsigned NUM_IN   = 16;
  localparam int unsigned NUM_OUT  = 16;
  localparam int unsigned NUM_SRC  = 5;
  localparam int unsigned NUM_IRQ  = 4;
  localparam logic [9:0]  WDOG_BASE = 10'h008;

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_EXEC, S_WAIT, S_DELAY, S_HOLD} seq_state_t;

endpackage

/* File: seq_sync2.sv */
// Two-flop synchroniser for a bundle of unrelated level inputs.
// Assumes each bit changes slowly compared with clk_i; no bus coherence.
`timescale 1ns/1ps
module seq_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_st_t;

  sync_st_t s_reg;
  sync_st_t s_next;

  // First stage feeds only the second stage
  always_comb begin
    s_next      = s_reg;
    s_next.meta = d_i;
    s_next.sync = s_reg.meta;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_o = s_reg.sync;
endmodule

/* File: seq_queue_mem.sv */
// Eight-entry step queue, one write port and two registered read ports.
// Port a serves the sequencer, port b serves bus read-back.
`timescale 1ns/1ps
module seq_queue_mem (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_en_i,
  input  wire logic [2:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic [2:0] rd_addr_a_i,
  output logic      [7:0] rd_data_a_o,
  input  wire logic [2:0] rd_addr_b_i,
  output logic      [7:0] rd_data_b_o
);
  typedef struct packed {
    logic [7:0][7:0] mem;
    logic [7:0]      rda;
    logic [7:0]      rdb;
  } mem_st_t;

  mem_st_t s_reg;
  mem_st_t s_next;

  // Read before write: a same-cycle write shows one cycle later
  always_comb begin
    s_next     = s_reg;
    s_next.rda = s_reg.mem[rd_addr_a_i];
    s_next.rdb = s_reg.mem[rd_addr_b_i];
    if (wr_en_i) begin
      s_next.mem[wr_addr_i] = wr_data_i;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data_a_o = s_reg.rda;
  assign rd_data_b_o = s_reg.rdb;
endmodule

/* File: periph_model.sv */
// Stand-in for the on-chip peripherals around the trigger sequencer.
// Assumes the sequencer's clock; input 1 echoes output 0 three clocks late.
`timescale 1ns/1ps
module periph_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] trig_out_i,
  output logic      [15:0] trig_in_o
);
  logic [2:0] dly_reg;
  // Echo path, so a wait step can be released by an earlier trigger step
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_reg <= 3'h0;
    end else begin
      dly_reg <= {dly_reg[1:0], trig_out_i[0]};
    end
  end
  // Other inputs stay low: input 2 never answers, for watchdog runs
  assign trig_in_o = {14'h0000, dly_reg[2], 1'b0};
endmodule

/* File: peripheral_trigger_sequencer_tb_top.sv */
// Self-checking bench for trigger_sequencer with the peripheral model.
// Assumes a 100 MHz clock and the bus map of seq_pkg.
`timescale 1ns/1ps
module peripheral_trigger_sequencer_tb_top;
  import seq_pkg::*;
  typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic        idle  = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] dat_o, rd;
  logic        ack_o, step_irq_o, wdt_irq_o;
  logic [15:0] trig_in, trig_out_o;
  logic [3:0]  irq_o;
  wire  [21:0] obs = {wdt_irq_o, step_irq_o, irq_o, trig_out_o};
  int          errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          w;
  row_t        rows [5] = '{'{OFS_CON, 16'hFFFF, 16'hFFF7}, '{OFS_CON, 16'h0030, 16'h0030},
    '{OFS_T0LIM, 16'h1234, 16'h1234}, '{8'h1C, 16'hFFFF, 16'h0000},
    '{OFS_CST, 16'h0003, 16'h0003}};

  trigger_sequencer DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .idle_i(idle),
    .trig_in_i(trig_in), .clk_src_i(5'h00), .trig_out_o(trig_out_o), .irq_o(irq_o),
    .step_irq_o(step_irq_o), .wdt_irq_o(wdt_irq_o));
  periph_model peer (.clk_i(clk_i), .rst_i(rst_i), .trig_out_i(trig_out_o),
    .trig_in_o(trig_in));

  // ****************************************************************
  // Clock, timeout and closing report
  // ****************************************************************
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Bus cycle, compare and output watch
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Request held until ack is sampled high; one idle cycle follows
  task automatic bus(input logic [7:0] a, input logic wr, input logic [15:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= wr;
    adr  <= a;
    wdat <= {16'h0000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Wait for an output bit to rise, then count the cycles it stays high
  task automatic pulse(input int n, output int wd);
    int k;
    k  = 0;
    wd = 0;
    while (obs[n] !== 1'b1 && k < 300) begin
      @(posedge clk_i);
      k++;
    end
    while (obs[n] === 1'b1 && wd < 300) begin
      @(posedge clk_i);
      wd++;
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(OFS_CST, 1'b0, 16'h0);
    chk(rd, 32'h0);
    foreach (rows[i]) begin
      bus(rows[i].a, 1'b1, rows[i].d);
      bus(rows[i].a, 1'b0, 16'h0);
      chk(rd, {16'h0, rows[i].e});
    end
    // Pulse mode, width four from the config row above
    bus(OFS_QUE, 1'b1, 16'h0030);
    bus(OFS_CST, 1'b1, 16'h8080);
    pulse(0, w);
    chk(32'(w), 32'd4);
    bus(OFS_CST, 1'b1, 16'h0000);
    repeat (3) @(posedge clk_i);
    chk({16'h0, trig_out_o}, 32'h0);
    // Toggle mode holds the output across a whole program loop
    bus(OFS_CST, 1'b1, 16'h9080);
    pulse(0, w);
    chk(32'(w > 8), 32'd1);
    bus(OFS_CST, 1'b1, 16'h0000);
    // Wait on input 1 (edge, no exit delay), then trigger 1 and interrupt 0
    bus(OFS_QUE + 8'h04, 1'b1, 16'h0011);
    bus(OFS_QUE + 8'h08, 1'b1, 16'h0031);
    bus(OFS_QUE + 8'h0C, 1'b1, 16'h0040);
    bus(OFS_CST, 1'b1, 16'h8081);
    pulse(1, w);
    chk(32'(w), 32'd4);
    pulse(16, w);
    chk(32'(w), 32'd1);
    bus(OFS_CST, 1'b1, 16'h0000);
    bus(OFS_CST, 1'b1, 16'h8281);
    pulse(20, w);
    chk(32'(w), 32'd1);
    // Timer then soft trigger; idle stop freezes it, live timer reads back
    bus(OFS_CST, 1'b1, 16'h0000);
    bus(OFS_CON, 1'b1, 16'h0000);
    bus(OFS_T0LIM, 1'b1, 16'h0005);
    bus(OFS_QUE, 1'b1, 16'h0001);
    bus(OFS_QUE + 8'h04, 1'b1, 16'h0003);
    idle <= 1'b1;
    bus(OFS_CST, 1'b1, 16'hA580);
    repeat (20) @(posedge clk_i);
    chk({16'h0, trig_out_o}, 32'h0);
    bus(OFS_T0LIM, 1'b0, 16'h0);
    chk(rd, 32'h0);
    idle <= 1'b0;
    pulse(1, w);
    chk(32'(w), 32'd1);
    // Input 2 never answers: watchdog of eight clocks halts the run
    bus(OFS_CST, 1'b1, 16'h0000);
    bus(OFS_QUE, 1'b1, 16'h0012);
    bus(OFS_CON, 1'b1, 16'h0031);
    bus(OFS_CST, 1'b1, 16'h8081);
    pulse(21, w);
    chk(32'(w), 32'd1);
    bus(OFS_CST, 1'b0, 16'h0);
    chk(rd, 32'h8041);
    end_of_test();
  end
endmodule
